// ### src/ccad_pkg.sv
package ccad_pkg;

   // Core clock rate used to turn times into cycle counts
   localparam int CLK_MHZ = 250;

   // Comparator vector layout, one group per CC pin
   localparam int CMP_RA  = 0;  // Below active_cable_threshold
   localparam int CMP_RD  = 1;  // Below sink_detach_threshold
   localparam int CMP_DEF = 2;  // Sink: above default-current level
   localparam int CMP_1P5 = 3;  // Sink: above 1.5 A level
   localparam int CMP_3P0 = 4;  // Sink: above 3 A level
   localparam int CMP_W   = 5;

   // Debounce counter width and reset value
   localparam int         DBNC_W   = 16;
   localparam logic [15:0] DBNC_RST = 16'h0000;

   // Pull-up advertisement levels (source side) and decoded partner current (sink side)
   typedef enum logic [1:0] {
      ADV_DEF_500 = 2'h0,
      ADV_DEF_900 = 2'h1,
      ADV_1P5     = 2'h2,
      ADV_3P0     = 2'h3
   } ccad_adv_type;

   // Classified pin termination
   typedef enum logic [2:0] {
      PIN_OPEN = 3'h1,
      PIN_RA   = 3'h2,
      PIN_RD   = 3'h4
   } ccad_pin_type;

   // Connection states
   typedef enum logic [6:0] {
      ST_UNATT     = 7'h01,
      ST_SRC_ATT   = 7'h02,
      ST_CABLE     = 7'h04,
      ST_SRC_CABLE = 7'h08,
      ST_DEBUG     = 7'h10,
      ST_AUDIO     = 7'h20,
      ST_SNK_ATT   = 7'h40
   } ccad_state_type;

   // Discharge timer width
   localparam int SAFE0_W = 24;

endpackage

// ### src/ccad_debounce.sv
`timescale 1ns/100ps
module ccad_debounce #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        arst_n,
   // Debounce interval in core cycles
   input  wire logic [ccad_pkg::DBNC_W-1:0] dbnc_cycles,
   // Raw and filtered comparator levels
   input  wire logic [WIDTH-1:0]            raw_in,
   output logic      [WIDTH-1:0]            stable_out
);
   import ccad_pkg::*;

   logic [WIDTH-1:0]  meta_r;
   logic [WIDTH-1:0]  sync_r;
   logic [WIDTH-1:0]  cand_r;
   logic [WIDTH-1:0]  cand_nxt;
   logic [WIDTH-1:0]  stable_r;
   logic [WIDTH-1:0]  stable_nxt;
   logic [DBNC_W-1:0] cnt_r;
   logic [DBNC_W-1:0] cnt_nxt;

   // Two-flop synchroniser per bit; first stage feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               meta_r[gi] <= 1'b0;
               sync_r[gi] <= 1'b0;
            end else begin
               meta_r[gi] <= raw_in[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   // Whole vector must hold still; a chattering bit restarts the wait
   always_comb begin
      cand_nxt   = sync_r;
      cnt_nxt    = cnt_r;
      stable_nxt = stable_r;
      if (sync_r != cand_r) begin
         cnt_nxt = DBNC_RST;
      end else if (cand_r != stable_r) begin
         if (cnt_r >= dbnc_cycles) begin
            stable_nxt = cand_r;
            cnt_nxt    = DBNC_RST;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cand_r   <= '0;
         stable_r <= '0;
         cnt_r    <= DBNC_RST;
      end else begin
         cand_r   <= cand_nxt;
         stable_r <= stable_nxt;
         cnt_r    <= cnt_nxt;
      end
   end

   assign stable_out = stable_r;

endmodule

// ### src/ccad_attach.sv
`timescale 1ns/100ps
module ccad_attach #(
   parameter int SAFE0_TIME_US = 650,
   parameter int SAFE0_CYC     = SAFE0_TIME_US * ccad_pkg::CLK_MHZ
) (
   // Clock and reset
   input  wire logic                             clk_sys,
   input  wire logic                             arst_n,
   // Configuration
   input  wire logic                             snk_role_sel,
   input  wire ccad_pkg::ccad_adv_type           adv_level,
   input  wire logic [ccad_pkg::DBNC_W-1:0]      dbnc_cycles,
   // CC comparator results per pin
   input  wire logic [ccad_pkg::CMP_W-1:0]       cc_pin_one_cmp,
   input  wire logic [ccad_pkg::CMP_W-1:0]       cc_pin_two_cmp,
   // VBUS and supply sensing
   input  wire logic                             vbus_present,
   input  wire logic                             vbus_above_safe5v,
   input  wire logic                             vbus_above_safe0v,
   input  wire logic                             hv_path_en,
   input  wire logic                             safe0_req,
   input  wire logic                             vconn_supply_input_good,
   // CC pin terminations
   output logic [1:0]                            cc_pullup_current_en,
   output ccad_pkg::ccad_adv_type                cc_pullup_level,
   output logic [1:0]                            trimmed_sink_pulldown_en,
   // Power controls
   output logic                                  vbus_src_en,
   output logic [1:0]                            vconn_en,
   output logic                                  vconn_ilim_en,
   output logic                                  vbus_pulldown_en,
   output logic                                  safe0_timeout,
   // Status and events
   output ccad_pkg::ccad_state_type              conn_state,
   output logic                                  orient_flip,
   output logic [1:0]                            monitor_pins,
   output ccad_pkg::ccad_adv_type                snk_adv_current,
   output logic                                  attach_evt,
   output logic                                  detach_evt
);
   import ccad_pkg::*;

   localparam logic [SAFE0_W-1:0] SAFE0_LIM = SAFE0_W'(SAFE0_CYC);

   logic [2*CMP_W-1:0] cmp_stable;
   logic [CMP_W-1:0]   c1;
   logic [CMP_W-1:0]   c2;
   ccad_pin_type       p1;
   ccad_pin_type       p2;
   ccad_state_type     st_r;
   ccad_state_type     st_nxt;
   logic               flip_r;
   logic               flip_nxt;
   logic               role_r;
   logic               attach_r;
   logic               attach_nxt;
   logic               detach_r;
   logic               detach_nxt;
   ccad_adv_type       snk_cur_r;
   ccad_adv_type       snk_cur_nxt;
   logic [1:0]         vconn_r;
   logic [1:0]         vconn_nxt;
   logic [1:0]         vconn_req;
   logic               safe0_r;
   logic               safe0_nxt;
   logic [SAFE0_W-1:0] s0cnt_r;
   logic [SAFE0_W-1:0] s0cnt_nxt;
   logic               s0to_r;
   logic               s0to_nxt;

   // Sync and debounce both pins together
   ccad_debounce #(
      .WIDTH (2*CMP_W)
   ) u_dbnc (
      .clk_sys     (clk_sys),
      .arst_n      (arst_n),
      .dbnc_cycles (dbnc_cycles),
      .raw_in      ({cc_pin_two_cmp, cc_pin_one_cmp}),
      .stable_out  (cmp_stable)
   );

   assign c1 = cmp_stable[CMP_W-1:0];
   assign c2 = cmp_stable[2*CMP_W-1:CMP_W];

   // Threshold pair per pin; analog side picks thresholds from cc_pullup_level
   function automatic ccad_pin_type classify(input logic [CMP_W-1:0] c);
      if (c[CMP_RA]) begin
         return PIN_RA;
      end else if (c[CMP_RD]) begin
         return PIN_RD;
      end
      return PIN_OPEN;
   endfunction

   // Sink side current decode, highest level wins
   function automatic ccad_adv_type decode_cur(input logic [CMP_W-1:0] c);
      if (c[CMP_3P0]) begin
         return ADV_3P0;
      end else if (c[CMP_1P5]) begin
         return ADV_1P5;
      end
      return ADV_DEF_500;
   endfunction

   assign p1 = classify(c1);
   assign p2 = classify(c2);

   // Connection state machine; role change always drops to unattached
   always_comb begin
      st_nxt      = st_r;
      flip_nxt    = flip_r;
      snk_cur_nxt = snk_cur_r;
      case (st_r)
         ST_UNATT: begin
            if (snk_role_sel) begin
               if (vbus_present && (c1[CMP_DEF] || c2[CMP_DEF])) begin
                  st_nxt   = ST_SNK_ATT;
                  flip_nxt = !c1[CMP_DEF];
               end
            end else if (p1 == PIN_RD && p2 == PIN_OPEN) begin
               st_nxt   = ST_SRC_ATT;
               flip_nxt = 1'b0;
            end else if (p1 == PIN_OPEN && p2 == PIN_RD) begin
               st_nxt   = ST_SRC_ATT;
               flip_nxt = 1'b1;
            end else if (p1 == PIN_RA && p2 == PIN_OPEN) begin
               st_nxt   = ST_CABLE;
               flip_nxt = 1'b1;
            end else if (p1 == PIN_OPEN && p2 == PIN_RA) begin
               st_nxt   = ST_CABLE;
               flip_nxt = 1'b0;
            end else if (p1 == PIN_RA && p2 == PIN_RD) begin
               st_nxt   = ST_SRC_CABLE;
               flip_nxt = 1'b1;
            end else if (p1 == PIN_RD && p2 == PIN_RA) begin
               st_nxt   = ST_SRC_CABLE;
               flip_nxt = 1'b0;
            end else if (p1 == PIN_RD && p2 == PIN_RD) begin
               st_nxt = ST_DEBUG;
            end else if (p1 == PIN_RA && p2 == PIN_RA) begin
               st_nxt = ST_AUDIO;
            end
         end
         ST_CABLE: begin
            // flip_r names the pin where a sink may still appear
            if ((flip_r ? p1 : p2) == PIN_OPEN) begin
               st_nxt = ST_UNATT;
            end else if ((flip_r ? p2 : p1) == PIN_RD) begin
               st_nxt = ST_SRC_CABLE;
            end
         end
         ST_SRC_ATT, ST_SRC_CABLE: begin
            if ((flip_r ? p2 : p1) == PIN_OPEN) begin
               st_nxt = ST_UNATT;
            end
         end
         ST_DEBUG, ST_AUDIO: begin
            if (p1 == PIN_OPEN || p2 == PIN_OPEN) begin
               st_nxt = ST_UNATT;
            end
         end
         ST_SNK_ATT: begin
            snk_cur_nxt = decode_cur(flip_r ? c2 : c1);
            if (!vbus_present) begin
               st_nxt = ST_UNATT;
            end
         end
         default: begin
            st_nxt = ST_UNATT;
         end
      endcase
      if (snk_role_sel != role_r) begin
         st_nxt = ST_UNATT;
      end
      if (st_nxt == ST_UNATT) begin
         snk_cur_nxt = ADV_DEF_500;
      end
      attach_nxt = (st_r == ST_UNATT) && (st_nxt != ST_UNATT);
      detach_nxt = (st_r != ST_UNATT) && (st_nxt == ST_UNATT);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r      <= ST_UNATT;
         flip_r    <= 1'b0;
         role_r    <= 1'b0;
         attach_r  <= 1'b0;
         detach_r  <= 1'b0;
         snk_cur_r <= ADV_DEF_500;
      end else begin
         st_r      <= st_nxt;
         flip_r    <= flip_nxt;
         role_r    <= snk_role_sel;
         attach_r  <= attach_nxt;
         detach_r  <= detach_nxt;
         snk_cur_r <= snk_cur_nxt;
      end
   end

   // VCONN goes to the cable pin, never the monitored one; follows the next state
   // so the switch opens on the detach edge itself, never powered while unattached
   assign vconn_req = (st_nxt == ST_SRC_CABLE) ? (flip_nxt ? 2'h1 : 2'h2) : 2'h0;

   // Input-good gates only the closing edge; a closed switch stays closed
   always_comb begin
      vconn_nxt = vconn_req;
      if (vconn_r != vconn_req && !vconn_supply_input_good) begin
         vconn_nxt = 2'h0;
      end else if (vconn_r == vconn_req) begin
         vconn_nxt = vconn_r;
      end
   end

   // Discharge to vSafe0V after a detach or on request, with a time budget
   always_comb begin
      safe0_nxt = safe0_r;
      s0cnt_nxt = s0cnt_r;
      s0to_nxt  = 1'b0;
      if (!safe0_r && (safe0_req || detach_nxt)) begin
         safe0_nxt = 1'b1;
         s0cnt_nxt = '0;
      end else if (safe0_r) begin
         if (!vbus_above_safe0v) begin
            safe0_nxt = 1'b0;
         end else if (s0cnt_r == SAFE0_LIM) begin
            s0to_nxt = 1'b1;  // Overrun flagged, pull-down keeps going
         end else begin
            s0cnt_nxt = s0cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         vconn_r <= 2'h0;
         safe0_r <= 1'b0;
         s0cnt_r <= '0;
         s0to_r  <= 1'b0;
      end else begin
         vconn_r <= vconn_nxt;
         safe0_r <= safe0_nxt;
         s0cnt_r <= s0cnt_nxt;
         s0to_r  <= s0to_nxt;
      end
   end

   // Terminations: pull-ups in source role, except on the VCONN pin
   assign cc_pullup_current_en     = role_r ? 2'h0 : ~vconn_r;
   assign cc_pullup_level          = adv_level;
   assign trimmed_sink_pulldown_en = role_r ? 2'h3 : 2'h0;

   // Power and status outputs
   assign vbus_src_en      = (st_r == ST_SRC_ATT) || (st_r == ST_SRC_CABLE);
   assign vconn_en         = vconn_r;
   assign vconn_ilim_en    = |vconn_r;
   assign vbus_pulldown_en = (!hv_path_en && vbus_above_safe5v) || safe0_r;
   assign safe0_timeout    = s0to_r;
   assign conn_state       = st_r;
   assign orient_flip      = flip_r;
   assign monitor_pins     = (st_r == ST_SRC_ATT || st_r == ST_SRC_CABLE)
                             ? (flip_r ? 2'h2 : 2'h1) : 2'h3;
   assign snk_adv_current  = snk_cur_r;
   assign attach_evt       = attach_r;
   assign detach_evt       = detach_r;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_acc_open;
      (st_r == ST_DEBUG || st_r == ST_AUDIO) && (p1 == PIN_OPEN || p2 == PIN_OPEN)
         && (snk_role_sel == role_r);
   endsequence

   sequence s_leave_unatt;
      (st_r == ST_UNATT) ##1 (st_r != ST_UNATT);
   endsequence

   AST_UNATT_DARK: assert property ((st_r == ST_UNATT) |-> !vbus_src_en && vconn_en == 2'h0)
      else $error("Power applied while unattached");
   AST_RD_ONE: assert property ((st_r == ST_SRC_ATT && !flip_r)
      |-> vbus_src_en && vconn_en == 2'h0 && monitor_pins == 2'h1)
      else $error("Pin one sink handling wrong");
   AST_RD_TWO: assert property ((st_r == ST_SRC_ATT && flip_r)
      |-> vbus_src_en && vconn_en == 2'h0 && monitor_pins == 2'h2)
      else $error("Pin two sink handling wrong");
   AST_CABLE_ONLY: assert property ((st_r == ST_CABLE)
      |-> !vbus_src_en && vconn_en == 2'h0 && monitor_pins == 2'h3)
      else $error("Cable-only state powered");
   AST_VCONN_ONE: assert property ((st_r == ST_SRC_CABLE && flip_r)
      |-> vbus_src_en && vconn_en != 2'h2 && monitor_pins == 2'h2)
      else $error("VCONN on wrong pin");
   AST_VCONN_TWO: assert property ((st_r == ST_SRC_CABLE && !flip_r)
      |-> vbus_src_en && vconn_en != 2'h1 && monitor_pins == 2'h1)
      else $error("VCONN on wrong pin");
   AST_ACC_DETACH: assert property (s_acc_open |=> (st_r == ST_UNATT) && detach_evt)
      else $error("Accessory detach missed");
   AST_VCONN_ONEHOT: assert property ($onehot0(vconn_en) && (vconn_en & monitor_pins) == 2'h0)
      else $error("VCONN not on a single unmonitored pin");
   AST_VCONN_CLOSE: assert property ($rose(|vconn_en) |-> $past(vconn_supply_input_good))
      else $error("VCONN closed without input good");
   AST_SNK_VBUS: assert property ($rose(st_r == ST_SNK_ATT) |-> $past(vbus_present))
      else $error("Sink attach without VBUS");
   AST_DISCHARGE: assert property ((!hv_path_en && vbus_above_safe5v) |-> vbus_pulldown_en)
      else $error("VBUS pull-down not enabled");
   AST_ATTACH_EVT: assert property (s_leave_unatt |-> attach_evt ##1 !attach_evt)
      else $error("Attach event not a single pulse");

endmodule

// ### tb/ccad_partner_model.sv
`timescale 1ns/100ps
module ccad_partner_model
   import ccad_pkg::*;
(
   // Far-side termination per pin: 0 open, 1 Ra, 2 Rd, 3 source pull-up
   input  wire logic [1:0]       term_one,
   input  wire logic [1:0]       term_two,
   // Far-side source advertisement and VBUS switch
   input  wire ccad_adv_type     src_adv,
   input  wire logic             src_vbus_on,
   // Device terminations and power
   input  wire logic [1:0]       cc_pullup_current_en,
   input  wire logic [1:0]       trimmed_sink_pulldown_en,
   input  wire logic             vbus_src_en,
   // Comparator results and VBUS sense
   output logic [CMP_W-1:0]      cc_pin_one_cmp,
   output logic [CMP_W-1:0]      cc_pin_two_cmp,
   output logic                  vbus_present
);
   // A pin with no pull-up on it (VCONN applied) reads above every threshold, like open
   function automatic logic [CMP_W-1:0] pin_cmp(input logic [1:0] t, input logic pu,
                                                 input logic pd, input ccad_adv_type a);
      logic [CMP_W-1:0] c;
      c = '0;
      if (pu && t == 2'h1) c = 5'h03;
      if (pu && t == 2'h2) c = 5'h02;
      // Far-side pull-up only shows against the device pull-down
      if (pd && t == 2'h3) begin
         c[CMP_DEF] = 1'b1;
         c[CMP_1P5] = (a == ADV_1P5) || (a == ADV_3P0);
         c[CMP_3P0] = (a == ADV_3P0);
      end
      return c;
   endfunction

   // Same comparator model on both pins
   assign cc_pin_one_cmp = pin_cmp(term_one, cc_pullup_current_en[0],
                                   trimmed_sink_pulldown_en[0], src_adv);
   assign cc_pin_two_cmp = pin_cmp(term_two, cc_pullup_current_en[1],
                                   trimmed_sink_pulldown_en[1], src_adv);
   // VBUS from our own switch or from an attached far-side source
   assign vbus_present = vbus_src_en | (src_vbus_on & (term_one == 2'h3 | term_two == 2'h3));
endmodule

// ### tb/ccad_attach_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: %s", $time, m); end end
module ccad_attach_tb_top;
   import ccad_pkg::*;
   localparam logic [1:0] T_OPEN = 2'h0, T_RA = 2'h1, T_RD = 2'h2, T_SRC = 2'h3;
   // Stimulus
   logic             clk_sys = 1'b0;
   logic             arst_n = 1'b0;
   logic             snk_role_sel = 1'b0;
   ccad_adv_type     adv_level = ADV_DEF_500;
   ccad_adv_type     src_adv = ADV_DEF_500;
   logic [15:0]      dbnc_cycles = 16'h0004;
   logic [1:0]       term_one = 2'h0, term_two = 2'h0;
   logic             src_vbus_on = 1'b0, vbus_above_safe5v = 1'b0, vbus_above_safe0v = 1'b0;
   logic             hv_path_en = 1'b1, safe0_req = 1'b0, vconn_supply_input_good = 1'b1;
   // Design outputs and partner results
   logic [CMP_W-1:0] cc_pin_one_cmp, cc_pin_two_cmp;
   logic             vbus_present, vbus_src_en, vconn_ilim_en, vbus_pulldown_en;
   logic             safe0_timeout, orient_flip, attach_evt, detach_evt;
   logic [1:0]       cc_pullup_current_en, trimmed_sink_pulldown_en, vconn_en, monitor_pins;
   ccad_adv_type     cc_pullup_level, snk_adv_current;
   ccad_state_type   conn_state, prev_st;
   int               n_fail = 0;
   int               checks_done = 0;

   // Short discharge budget keeps the overrun case quick
   ccad_attach #(.SAFE0_CYC(20)) i_dut (
      .clk_sys, .arst_n, .snk_role_sel, .adv_level, .dbnc_cycles, .cc_pin_one_cmp,
      .cc_pin_two_cmp, .vbus_present, .vbus_above_safe5v, .vbus_above_safe0v, .hv_path_en,
      .safe0_req, .vconn_supply_input_good, .cc_pullup_current_en, .cc_pullup_level,
      .trimmed_sink_pulldown_en, .vbus_src_en, .vconn_en, .vconn_ilim_en, .vbus_pulldown_en,
      .safe0_timeout, .conn_state, .orient_flip, .monitor_pins, .snk_adv_current,
      .attach_evt, .detach_evt);
   ccad_partner_model i_partner (
      .term_one, .term_two, .src_adv, .src_vbus_on, .cc_pullup_current_en,
      .trimmed_sink_pulldown_en, .vbus_src_en, .cc_pin_one_cmp, .cc_pin_two_cmp,
      .vbus_present);

   // 250 MHz core clock
   always #2 clk_sys = ~clk_sys;

   // Events must land on the edge that leaves or enters unattached
   always @(posedge clk_sys) begin
      #1;
      if (arst_n) begin
         `CHK(attach_evt, prev_st == ST_UNATT && conn_state != ST_UNATT, "attach pulse")
         `CHK(detach_evt, prev_st != ST_UNATT && conn_state == ST_UNATT, "detach pulse")
      end
      prev_st = conn_state;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Bounded wait; an intermediate cable state is allowed on the way
   task automatic wait_st(input ccad_state_type st);
      int i;
      i = 0;
      while (conn_state !== st && i < 60) begin
         step(1);
         i++;
      end
      if (conn_state !== st) begin
         n_fail++;
         $display("wrong value at %0t: state wait ran out", $time);
         wrap_up();
      end
   endtask

   task automatic t_reset;
      `CHK(conn_state, ST_UNATT, "reset state")
      `CHK(vbus_src_en, 1'b0, "reset vbus")
      `CHK(vconn_en, 2'h0, "reset vconn")
      `CHK(monitor_pins, 2'h3, "reset watch")
      `CHK(cc_pullup_current_en, 2'h3, "reset pull-up")
   endtask

   // One source-role attach, hold and detach
   task automatic src_case(input logic [1:0] t1, t2, input ccad_state_type st,
                           input logic vb, input logic [1:0] vc, mon, input logic fl);
      term_one = t1;
      term_two = t2;
      wait_st(st);
      step(3);
      `CHK(vbus_src_en, vb, "vbus enable")
      `CHK(vconn_en, vc, "vconn pin")
      `CHK(vconn_ilim_en, |vc, "vconn limit")
      `CHK(cc_pullup_current_en, ~vc, "pull-up pins")
      `CHK(monitor_pins, mon, "detach watch")
      if (st != ST_DEBUG && st != ST_AUDIO) `CHK(orient_flip, fl, "orientation")
      step(20);
      `CHK(conn_state, st, "held state")
      term_one = T_OPEN;
      term_two = T_OPEN;
      wait_st(ST_UNATT);
      step(4);
   endtask

   // Short glitch ignored, steady change not taken early
   task automatic t_dbnc;
      term_one = T_RD;
      step(2);
      term_one = T_OPEN;
      step(30);
      `CHK(conn_state, ST_UNATT, "glitch taken")
      term_one = T_RD;
      step(dbnc_cycles + 4);
      `CHK(conn_state, ST_UNATT, "taken before debounce")
      step(1);
      `CHK(conn_state, ST_SRC_ATT, "debounce too long")
      wait_st(ST_SRC_ATT);
      term_one = T_OPEN;
      wait_st(ST_UNATT);
      step(4);
   endtask

   // Cable first, then sink; switch waits for input good, then ignores its loss
   task automatic t_vconn;
      vconn_supply_input_good = 1'b0;
      term_one = T_RA;
      wait_st(ST_CABLE);
      `CHK(vbus_src_en, 1'b0, "cable vbus")
      term_two = T_RD;
      wait_st(ST_SRC_CABLE);
      step(10);
      `CHK(vconn_en, 2'h0, "closed without good")
      vconn_supply_input_good = 1'b1;
      step(3);
      `CHK(vconn_en, 2'h1, "not closed")
      vconn_supply_input_good = 1'b0;
      step(10);
      `CHK(vconn_en, 2'h1, "opened on loss")
      term_one = T_OPEN;
      term_two = T_OPEN;
      wait_st(ST_UNATT);
      `CHK(vconn_en, 2'h0, "vconn left on")
      step(2);
      vconn_supply_input_good = 1'b1;
   endtask

   task automatic t_adv;
      for (int i = 0; i < 4; i++) begin
         adv_level = ccad_adv_type'(i);
         step(1);
         `CHK(cc_pullup_level, ccad_adv_type'(i), "advertisement")
      end
   endtask

   // Sink: pull-up alone never attaches, VBUS does; current decoded
   task automatic sink_case(input logic two, input ccad_adv_type a, e);
      src_adv = a;
      if (two) term_two = T_SRC;
      else term_one = T_SRC;
      step(20);
      `CHK(conn_state, ST_UNATT, "attach without vbus")
      src_vbus_on = 1'b1;
      wait_st(ST_SNK_ATT);
      step(2);
      `CHK(snk_adv_current, e, "sink current")
      `CHK(orient_flip, two, "sink orientation")
      src_vbus_on = 1'b0;
      wait_st(ST_UNATT);
      term_one = T_OPEN;
      term_two = T_OPEN;
      step(4);
   endtask

   task automatic t_dischg;
      vbus_above_safe5v = 1'b1;
      step(1);
      `CHK(vbus_pulldown_en, 1'b0, "pull-down with hv on")
      hv_path_en = 1'b0;
      step(1);
      `CHK(vbus_pulldown_en, 1'b1, "no pull-down")
      vbus_above_safe5v = 1'b0;
      step(1);
      `CHK(vbus_pulldown_en, 1'b0, "pull-down past 5 V")
      vbus_above_safe0v = 1'b1;
      safe0_req = 1'b1;
      step(1);
      safe0_req = 1'b0;
      step(10);
      `CHK(vbus_pulldown_en, 1'b1, "zero discharge")
      `CHK(safe0_timeout, 1'b0, "early timeout")
      step(15);
      `CHK(safe0_timeout, 1'b1, "overrun missed")
      `CHK(vbus_pulldown_en, 1'b1, "released early")
      vbus_above_safe0v = 1'b0;
      step(3);
      `CHK(vbus_pulldown_en, 1'b0, "held past 0 V")
      `CHK(safe0_timeout, 1'b0, "timeout stuck")
      hv_path_en = 1'b1;
   endtask

   initial begin
      prev_st = ST_UNATT;
      step(16);
      t_reset();
      arst_n = 1'b1;
      step(2);
      t_reset();
      t_dbnc();
      src_case(T_RD, T_OPEN, ST_SRC_ATT, 1'b1, 2'h0, 2'h1, 1'b0);
      src_case(T_OPEN, T_RD, ST_SRC_ATT, 1'b1, 2'h0, 2'h2, 1'b1);
      src_case(T_RA, T_OPEN, ST_CABLE, 1'b0, 2'h0, 2'h3, 1'b1);
      src_case(T_OPEN, T_RA, ST_CABLE, 1'b0, 2'h0, 2'h3, 1'b0);
      src_case(T_RA, T_RD, ST_SRC_CABLE, 1'b1, 2'h1, 2'h2, 1'b1);
      src_case(T_RD, T_RA, ST_SRC_CABLE, 1'b1, 2'h2, 2'h1, 1'b0);
      src_case(T_RD, T_RD, ST_DEBUG, 1'b0, 2'h0, 2'h3, 1'b0);
      src_case(T_RA, T_RA, ST_AUDIO, 1'b0, 2'h0, 2'h3, 1'b0);
      t_vconn();
      t_adv();
      snk_role_sel = 1'b1;
      step(3);
      `CHK(trimmed_sink_pulldown_en, 2'h3, "sink pull-down")
      `CHK(cc_pullup_current_en, 2'h0, "sink pull-up")
      sink_case(1'b0, ADV_DEF_500, ADV_DEF_500);
      sink_case(1'b1, ADV_1P5, ADV_1P5);
      sink_case(1'b0, ADV_3P0, ADV_3P0);
      snk_role_sel = 1'b0;
      step(3);
      t_dischg();
      wrap_up();
   end
endmodule
